// ==== core/gpio_pkg.sv ====
// Package of constants and carrier types for the general digital I/O port.
package gpio_pkg;

	// ----------------------------------------------------------------
	// Constants
	// ----------------------------------------------------------------
	localparam int          PORT_WIDTH         = 8;
	localparam int          PUD_BIT_POS        = 2;    // Pull-up disable position in the special function register.
	localparam logic        BIT_RESET_VALUE    = 1'h0;
	localparam logic [7:0]  PORT_RESET_VALUE   = 8'h00;

	// Write operations on a port register.
	typedef enum logic [1:0] {
		OP_NONE,
		OP_WRITE,
		OP_SET_BIT,
		OP_CLEAR_BIT
	} port_op_t;

	// Targets of a write operation.
	typedef enum logic {
		SEL_OUTPUT_VALUE,
		SEL_DIRECTION
	} port_sel_t;

	// One software access to the port.
	typedef struct packed {
		port_op_t   op;
		port_sel_t  sel;
		logic [2:0] bit_index;
		logic [7:0] data;
	} port_write_t;

	// Pad controls for one port.
	typedef struct packed {
		logic [7:0] drive_value;
		logic [7:0] drive_enable;
		logic [7:0] pullup_enable;
	} pad_ctrl_t;

endpackage

// ==== core/gpio_pin_sync.sv ====
// Latch-and-flop input synchroniser for one pin.
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_sync (
	// Clock and reset.
	input  wire logic i_clk,
	input  wire logic i_nrst,
	// Pin side.
	input  wire logic i_pin,
	input  wire logic i_clamp,
	// Sample side.
	output var  logic o_sample
);

	logic latch_q;
	logic sample_reg;
	logic sample_next;
	logic pin_gated;

	// Sleep clamp forces the input low ahead of the synchroniser.
	assign pin_gated = i_pin & ~i_clamp;

	// Latch is transparent while the clock is high and holds while low.
	// A non-blocking update keeps the sample flop reading the value held through the low phase.
	always_latch begin
		if (i_clk) begin
			latch_q <= pin_gated;
		end
	end

	// Next sample value is the held latch output.
	always_comb begin
		sample_next = latch_q;
	end

	// Sample flop takes the latch output on each rising edge.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			sample_reg <= gpio_pkg::BIT_RESET_VALUE;
		end else begin
			sample_reg <= sample_next;
		end
	end

	assign o_sample = sample_reg;

endmodule // gpio_pin_sync
`default_nettype wire

// ==== core/gpio_port.sv ====
// Top module of the general digital I/O port.
`timescale 1ns/10ps
`default_nettype none
module gpio_port #(
	parameter int WIDTH = gpio_pkg::PORT_WIDTH
) (
	// Clock and reset.
	input  wire logic               I_REF_CLK,
	input  wire logic               I_NRST,
	// Software access.
	input  wire gpio_pkg::port_write_t I_WRITE,
	input  wire logic [7:0]         I_SFIO_WRITE_DATA,
	input  wire logic               I_SFIO_WRITE,
	output var  logic [WIDTH-1:0]   O_OUTPUT_VALUE,
	output var  logic [WIDTH-1:0]   O_DIRECTION,
	output var  logic [WIDTH-1:0]   O_PIN_SAMPLE,
	output var  logic               O_GLOBAL_PULLUP_DISABLE,
	// Sleep and alternate functions.
	input  wire logic               I_SLEEP,
	input  wire logic [WIDTH-1:0]   I_CLAMP_OVERRIDE,
	input  wire logic [WIDTH-1:0]   I_ALT_ENABLE,
	input  wire logic [WIDTH-1:0]   I_ALT_DRIVE_ENABLE,
	input  wire logic [WIDTH-1:0]   I_ALT_DRIVE_VALUE,
	// Pads.
	input  wire logic [WIDTH-1:0]   I_PIN,
	output var  logic [WIDTH-1:0]   O_PIN,
	output var  logic [WIDTH-1:0]   O_PIN_OE,
	output var  logic [WIDTH-1:0]   O_PULLUP_EN
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] output_value_reg;
	logic [WIDTH-1:0] output_value_next;
	logic [WIDTH-1:0] direction_reg;
	logic [WIDTH-1:0] direction_next;
	logic             global_pullup_disable_reg;
	logic             global_pullup_disable_next;
	logic [WIDTH-1:0] pin_out_reg;
	logic [WIDTH-1:0] pin_out_next;
	logic [WIDTH-1:0] pin_oe_reg;
	logic [WIDTH-1:0] pin_oe_next;
	logic [WIDTH-1:0] pullup_reg;
	logic [WIDTH-1:0] pullup_next;
	logic [WIDTH-1:0] pin_sample_bit;
	logic [WIDTH-1:0] bit_mask;
	logic [WIDTH-1:0] bit_mask_reg;

	// ----------------------------------------------------------------
	// Software writes
	// ----------------------------------------------------------------
	// Software writes; set and clear touch only the addressed bit.
	// An index beyond the port width wraps onto the low bits.
	always_comb begin
		output_value_next          = output_value_reg;
		direction_next             = direction_reg;
		global_pullup_disable_next = global_pullup_disable_reg;
		bit_mask                   = '0;
		bit_mask[I_WRITE.bit_index[$clog2(WIDTH)-1:0]] = 1'b1;
		if (I_SFIO_WRITE) begin
			global_pullup_disable_next = I_SFIO_WRITE_DATA[gpio_pkg::PUD_BIT_POS];
		end
		unique case (I_WRITE.op)
			gpio_pkg::OP_NONE: begin
			end
			gpio_pkg::OP_WRITE: begin
				if (I_WRITE.sel == gpio_pkg::SEL_DIRECTION) begin
					direction_next = I_WRITE.data[WIDTH-1:0];
				end else begin
					output_value_next = I_WRITE.data[WIDTH-1:0];
				end
			end
			gpio_pkg::OP_SET_BIT: begin
				if (I_WRITE.sel == gpio_pkg::SEL_DIRECTION) begin
					direction_next = direction_reg | bit_mask;
				end else begin
					output_value_next = output_value_reg | bit_mask;
				end
			end
			gpio_pkg::OP_CLEAR_BIT: begin
				if (I_WRITE.sel == gpio_pkg::SEL_DIRECTION) begin
					direction_next = direction_reg & ~bit_mask;
				end else begin
					output_value_next = output_value_reg & ~bit_mask;
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Pad controls
	// ----------------------------------------------------------------
	// Pad controls of general pins follow the next register values so the pin moves on the write edge.
	// That keeps the pad one clock ahead of the synchroniser, which read-back relies on.
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			if (I_ALT_ENABLE[i]) begin
				pin_oe_next[i]  = I_ALT_DRIVE_ENABLE[i];
				pin_out_next[i] = I_ALT_DRIVE_VALUE[i] & I_ALT_DRIVE_ENABLE[i];
				pullup_next[i]  = 1'b0;
			end else begin
				pin_oe_next[i]  = direction_next[i];
				pin_out_next[i] = direction_next[i] & output_value_next[i];
				pullup_next[i]  = ~direction_next[i] & output_value_next[i]
					& ~global_pullup_disable_next;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Registers; reset clears everything, leaving the pins tri-stated.
	always_ff @(posedge I_REF_CLK) begin
		if (!I_NRST) begin
			output_value_reg          <= '0;
			direction_reg             <= '0;
			global_pullup_disable_reg <= gpio_pkg::BIT_RESET_VALUE;
			pin_out_reg               <= '0;
			pin_oe_reg                <= '0;
			pullup_reg                <= '0;
		end else begin
			output_value_reg          <= output_value_next;
			direction_reg             <= direction_next;
			global_pullup_disable_reg <= global_pullup_disable_next;
			pin_out_reg               <= pin_out_next;
			pin_oe_reg                <= pin_oe_next;
			pullup_reg                <= pullup_next;
		end
	end

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// One synchroniser per pin samples the pad whatever its direction.
	for (genvar g = 0; g < WIDTH; g++) begin : g_sync
		gpio_pin_sync u_sync (
			.i_clk    (I_REF_CLK),
			.i_nrst   (I_NRST),
			.i_pin    (I_PIN[g]),
			.i_clamp  (I_SLEEP & ~I_CLAMP_OVERRIDE[g]),
			.o_sample (pin_sample_bit[g])
		);
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Outputs straight from flops.
	assign O_OUTPUT_VALUE          = output_value_reg;
	assign O_DIRECTION             = direction_reg;
	assign O_PIN_SAMPLE            = pin_sample_bit;
	assign O_GLOBAL_PULLUP_DISABLE = global_pullup_disable_reg;
	assign O_PIN                   = pin_out_reg;
	assign O_PIN_OE                = pin_oe_reg;
	assign O_PULLUP_EN             = pullup_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_NRST);

	// Keeps the write mask of the previous edge so a checker can tell the touched pin from the rest.
	always_ff @(posedge I_REF_CLK) begin
		bit_mask_reg <= bit_mask;
	end

	// Reset must leave every pad undriven and unpulled, so this check stays live while reset is low.
	reset_tristate_a: assert property (disable iff (1'b0) !I_NRST |=> O_PIN_OE == '0 && O_PULLUP_EN == '0)
		else $error("Pins not tri-stated after reset.");
	pud_kills_pull_a: assert property (O_GLOBAL_PULLUP_DISABLE |-> O_PULLUP_EN == '0)
		else $error("Pull-up active while disabled.");

	// Pad controls of general pins follow the stored bits on the same edge as they are written.
	direction_drives_a: assert property ((I_ALT_ENABLE == '0) |=> O_PIN_OE == O_DIRECTION)
		else $error("Output enable does not follow direction.");
	output_level_a: assert property ((I_ALT_ENABLE == '0) |=> O_PIN == (O_DIRECTION & O_OUTPUT_VALUE))
		else $error("Driven level differs from output value.");
	pullup_rule_a: assert property ((I_ALT_ENABLE == '0) |=>
		O_PULLUP_EN == (~O_DIRECTION & O_OUTPUT_VALUE & {WIDTH{~O_GLOBAL_PULLUP_DISABLE}}))
		else $error("Pull-up state wrong.");
	alt_takeover_a: assert property (I_ALT_ENABLE != '0 |=>
		(O_PIN_OE & ~$past(I_ALT_ENABLE)) == (O_DIRECTION & ~$past(I_ALT_ENABLE))
		&& (O_PULLUP_EN & $past(I_ALT_ENABLE)) == '0)
		else $error("Alternate function disturbed a general pin.");

	// Set and clear on one pin must leave the other pins as they were.
	set_bit_only_a: assert property (I_WRITE.op == gpio_pkg::OP_SET_BIT
		&& I_WRITE.sel == gpio_pkg::SEL_DIRECTION
		|=> (O_DIRECTION & ~bit_mask_reg) == ($past(O_DIRECTION) & ~bit_mask_reg))
		else $error("Set disturbed other pins.");
	clear_bit_only_a: assert property (I_WRITE.op == gpio_pkg::OP_CLEAR_BIT
		&& I_WRITE.sel == gpio_pkg::SEL_OUTPUT_VALUE
		|=> (O_OUTPUT_VALUE & ~bit_mask_reg) == ($past(O_OUTPUT_VALUE) & ~bit_mask_reg)
		&& (O_OUTPUT_VALUE & bit_mask_reg) == '0)
		else $error("Clear disturbed other pins.");

	// Whole-register writes read back unchanged, and an SFIO write stores only its pull-up disable bit.
	write_readback_a: assert property (I_WRITE.op == gpio_pkg::OP_WRITE
		&& I_WRITE.sel == gpio_pkg::SEL_OUTPUT_VALUE
		|=> O_OUTPUT_VALUE == $past(I_WRITE.data[WIDTH-1:0]))
		else $error("Output value readback wrong.");
	dir_write_a: assert property (I_WRITE.op == gpio_pkg::OP_WRITE && I_WRITE.sel == gpio_pkg::SEL_DIRECTION
		|=> O_DIRECTION == $past(I_WRITE.data[WIDTH-1:0]))
		else $error("Direction readback wrong.");
	pud_write_a: assert property (I_SFIO_WRITE |=>
		O_GLOBAL_PULLUP_DISABLE == $past(I_SFIO_WRITE_DATA[gpio_pkg::PUD_BIT_POS]))
		else $error("Pull-up disable not taken from its bit.");

	// The sample bit shows the gated pad level held over the previous low phase.
	sample_path_a: assert property (I_NRST |=>
		O_PIN_SAMPLE == $past(I_PIN & ~({WIDTH{I_SLEEP}} & ~I_CLAMP_OVERRIDE)))
		else $error("Sample does not follow the pad.");
	sleep_clamp_a: assert property ((I_SLEEP && I_CLAMP_OVERRIDE == '0) [*2] |=> O_PIN_SAMPLE == '0)
		else $error("Clamped input reached sample.");

	// Main scenarios that the bench is expected to reach.
	out_high_c:    cover property (O_PIN_OE[0] && O_PIN[0]);
	pullup_c:      cover property (O_PULLUP_EN[0]);
	clear_c:       cover property (I_WRITE.op == gpio_pkg::OP_CLEAR_BIT);
	sleep_clamp_c: cover property (I_SLEEP && I_CLAMP_OVERRIDE == '0);
	alt_take_c:    cover property (I_ALT_ENABLE != '0 && O_PIN_OE != '0);

endmodule // gpio_port
`default_nettype wire

// ==== tb/gpio_pad_model.sv ====
// Behavioural model of the pads and the board around the port.
`timescale 1ns/10ps
`default_nettype none
module gpio_pad_model (
	// Clock.
	input  wire logic       i_clk,
	// Port side.
	input  wire logic [7:0] i_drive,
	input  wire logic [7:0] i_oe,
	input  wire logic [7:0] i_pullup,
	// Board side.
	input  wire logic [7:0] i_ext_en,
	input  wire logic [7:0] i_ext_val,
	output var  logic [7:0] o_pad
);
	// ----------------------------------------------------------------
	// Pad resolution
	// ----------------------------------------------------------------
	logic [7:0] float_reg = 8'h5A;

	// A floating pad wanders every cycle, so a missing pull-up shows.
	always_ff @(posedge i_clk) begin
		float_reg <= ~float_reg;
	end

	// The port driver wins, then the board, then the pull-up, then noise.
	always_comb begin
		o_pad = (i_oe & i_drive)
			| (~i_oe & i_ext_en & i_ext_val)
			| (~i_oe & ~i_ext_en & i_pullup)
			| (~i_oe & ~i_ext_en & ~i_pullup & float_reg);
	end
endmodule // gpio_pad_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking random bench for the general digital I/O port.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	// ----------------------------------------------------------------
	// Signals and reference state
	// ----------------------------------------------------------------
	logic                  clk;
	logic                  nrst;
	logic                  chk_on = 1'b0;
	gpio_pkg::port_write_t wr;
	logic                  sfio_wr, sleep, global_pullup_disable, m_pud;
	logic [7:0]            sfio_data, ovr, alt_en, alt_de, alt_dv, ext_en, ext_val;
	logic [7:0]            out_val, dir, samp, pin, oe, pu, pad, lat;
	logic [7:0]            m_out, m_dir, m_samp, m_alt_en, m_alt_de, m_alt_dv;
	gpio_pkg::pad_ctrl_t   e;
	int                    n_errors = 0;
	int                    tests_run = 0;
	int                    seed = 38987;

	gpio_port uut (.I_REF_CLK(clk), .I_NRST(nrst), .I_WRITE(wr), .I_SFIO_WRITE_DATA(sfio_data),
		.I_SFIO_WRITE(sfio_wr), .O_OUTPUT_VALUE(out_val), .O_DIRECTION(dir), .O_PIN_SAMPLE(samp),
		.O_GLOBAL_PULLUP_DISABLE(global_pullup_disable), .I_SLEEP(sleep), .I_CLAMP_OVERRIDE(ovr), .I_ALT_ENABLE(alt_en),
		.I_ALT_DRIVE_ENABLE(alt_de), .I_ALT_DRIVE_VALUE(alt_dv), .I_PIN(pad), .O_PIN(pin),
		.O_PIN_OE(oe), .O_PULLUP_EN(pu));
	gpio_pad_model board (.i_clk(clk), .i_drive(pin), .i_oe(oe), .i_pullup(pu), .i_ext_en(ext_en),
		.i_ext_val(ext_val), .o_pad(pad));

	// ----------------------------------------------------------------
	// Reference model and checks
	// ----------------------------------------------------------------
	// Applies one software operation to a stored register value.
	function automatic logic [7:0] apply(input logic [7:0] v, input gpio_pkg::port_write_t w);
		case (w.op)
			gpio_pkg::OP_WRITE: return w.data;
			gpio_pkg::OP_SET_BIT: return v | (8'h01 << w.bit_index);
			gpio_pkg::OP_CLEAR_BIT: return v & ~(8'h01 << w.bit_index);
			default: return v;
		endcase
	endfunction

	// Mirrors the stored state at every edge.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			{m_out, m_dir, m_samp, m_pud} <= 25'h0000000;
			{m_alt_en, m_alt_de, m_alt_dv} <= 24'h000000;
		end else begin
			m_samp <= lat;
			{m_alt_en, m_alt_de, m_alt_dv} <= {alt_en, alt_de, alt_dv};
			m_pud <= sfio_wr ? sfio_data[2] : m_pud;
			m_out <= (wr.sel == gpio_pkg::SEL_OUTPUT_VALUE) ? apply(m_out, wr) : m_out;
			m_dir <= (wr.sel == gpio_pkg::SEL_DIRECTION) ? apply(m_dir, wr) : m_dir;
		end
	end

	// Counts a comparison and reports a mismatch.
	task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Compares the stored registers and the pull-up disable.
	task automatic chk_regs(input logic [23:0] got, input logic [23:0] exp);
		chk(got, exp, "regs");
	endtask

	// Compares the pad controls; a level is only looked at where the pin is driven.
	task automatic chk_pads(input logic [23:0] got, input gpio_pkg::pad_ctrl_t x);
		chk(got, {x.drive_value & x.drive_enable, x.drive_enable, x.pullup_enable}, "pads");
	endtask

	// Compares the synchronised pin samples.
	task automatic chk_sample(input logic [7:0] got, input logic [7:0] exp);
		chk({16'h0000, got}, {16'h0000, exp}, "sample");
	endtask

	// The latch closes at the falling edge; outputs are settled there.
	always @(negedge clk) begin
		lat = pad & ~({8{sleep}} & ~ovr);
		e.drive_enable = (m_dir & ~m_alt_en) | (m_alt_de & m_alt_en);
		e.drive_value = (m_out & ~m_alt_en) | (m_alt_dv & m_alt_en);
		e.pullup_enable = ~m_dir & m_out & ~{8{m_pud}} & ~m_alt_en;
		if (chk_on) begin
			chk_regs({out_val, dir, 7'h00, global_pullup_disable}, {m_out, m_dir, 7'h00, m_pud});
			chk_pads({pin & e.drive_enable, oe, pu}, e);
			chk_sample(samp, m_samp);
		end
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic results();
		$display("mismatches %0d in %0d comparisons", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Drives one cycle; every input but the reset is randomised, and quiet holds the write at zero with no SFIO write.
	task automatic drive(input logic quiet);
		wr <= quiet ? 14'h0000 : 14'($random(seed));
		sfio_wr <= !quiet && (($random(seed) & 7) == 0);
		sfio_data <= 8'($random(seed));
		sleep <= ($random(seed) & 15) == 0;
		ovr <= 8'($random(seed));
		alt_en <= 8'($random(seed) & $random(seed) & $random(seed));
		{alt_de, alt_dv, ext_en, ext_val} <= 32'($random(seed));
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		#(5 * 4000);
		n_errors++;
		results();
	end

	// Reset, a hand-made opening, random traffic with a second reset.
	initial begin
		nrst = 1'b0;
		drive(1'b1);
		@(posedge clk);
		chk_on = 1'b1;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		wr <= {gpio_pkg::OP_WRITE, gpio_pkg::SEL_OUTPUT_VALUE, 3'h0, 8'hA5};
		{sfio_wr, sfio_data} <= 9'h104;
		@(posedge clk);
		wr <= {gpio_pkg::OP_WRITE, gpio_pkg::SEL_DIRECTION, 3'h0, 8'h0F};
		{sfio_wr, sfio_data} <= 9'h1FB;
		@(posedge clk);
		wr <= {gpio_pkg::OP_SET_BIT, gpio_pkg::SEL_DIRECTION, 3'h7, 8'h00};
		@(posedge clk);
		// Deep sleep with no override and a bit clear: every sample must read low.
		wr <= {gpio_pkg::OP_CLEAR_BIT, gpio_pkg::SEL_OUTPUT_VALUE, 3'h0, 8'h00};
		{sfio_wr, sleep, ovr, alt_en} <= 18'h10000;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk);
			nrst <= !(i >= 1500 && i < 1503);
			drive(i >= 1500 && i <= 1503);
		end
		repeat (3) @(posedge clk);
		results();
	end
endmodule // tb_top
`default_nettype wire
